// [common/ocp_pkg.sv]
// constants, field layouts and carrier types of the code-memory program and lock block
// assumes a 40 MHz pclk; pins from the device programmer arrive synchronous to it
// Operation
// - first lock: latch access pin, block reads, programming
// - second lock adds: verify reads return nothing
// - third lock adds: external execution forbidden
// - access latch keeps value until next reset
// - byte write self-timed, at most 80 us
// - polling returns inverted bit 7 while busy
// - ready/busy low after strobe, high when done
// - busy shows within 1.0 us of strobe
// - unlocked device returns code bytes for verify
// - lock bits never read out directly
// - signature bytes at three fixed addresses
// - verify data valid within 48 clocks of enable
// - address bit 14 on its own port-3 pin
package ocp_pkg;

  // ------------------------------------------------------------
  // memory geometry and timing
  // ------------------------------------------------------------
  localparam int ADDR_W        = 15;
  localparam int MEM_DEPTH     = 20480;
  localparam int CLK_MHZ       = 40;
  localparam int WR_TYP_NS     = 50000;   // typical byte write, 50 us
  localparam int WR_MAX_NS     = 80000;   // longest byte write, 80 us
  localparam int BUSY_MAX_NS   = 1000;    // strobe high to busy low, 1.0 us
  localparam int VERIFY_OSC    = 48;      // enable low to data valid, in clocks
  localparam int WR_TYP_CYC    = (WR_TYP_NS * CLK_MHZ) / 1000;
  localparam int WR_MAX_CYC    = (WR_MAX_NS * CLK_MHZ) / 1000;
  localparam int BUSY_MAX_CYC  = (BUSY_MAX_NS * CLK_MHZ) / 1000;

  // ------------------------------------------------------------
  // mode patterns {p2_6, p2_7, p3_3, p3_6, p3_7}
  // ------------------------------------------------------------
  localparam logic [4:0] MODE_WR_CODE = 5'h0f;
  localparam logic [4:0] MODE_RD_CODE = 5'h07;
  localparam logic [4:0] MODE_WR_LB1  = 5'h1f;
  localparam logic [4:0] MODE_WR_LB2  = 5'h1c;
  localparam logic [4:0] MODE_WR_LB3  = 5'h16;
  localparam logic [4:0] MODE_RD_LOCK = 5'h12;
  localparam logic [4:0] MODE_RD_SIG  = 5'h00;
  localparam int         MODE_EN_BIT  = 3;      // p2_7, the read enable, active low

  // ------------------------------------------------------------
  // signature locations and values (values arbitrary)
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SIG_ADDR_MAKER  = 15'h0000;
  localparam logic [ADDR_W-1:0] SIG_ADDR_FAMILY = 15'h0100;
  localparam logic [ADDR_W-1:0] SIG_ADDR_PART   = 15'h0200;
  localparam logic [7:0]        SIG_MAKER       = 8'h5a;
  localparam logic [7:0]        SIG_FAMILY      = 8'h3c;
  localparam logic [7:0]        SIG_PART        = 8'h11;

  // ------------------------------------------------------------
  // apb register map
  // ------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_WTIME  = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_WCOUNT = 12'h00c;
  localparam int          CTRL_PGM_EN_BIT    = 0;
  localparam int          STAT_BUSY_BIT      = 0;
  localparam int          STAT_EA_LATCH_BIT  = 1;
  localparam int          STAT_REFUSED_BIT   = 2;
  localparam logic        CTRL_PGM_EN_RST    = 1'b1;
  localparam logic [11:0] WTIME_RST          = 12'(WR_TYP_CYC);
  localparam logic [11:0] WTIME_MAX          = 12'(WR_MAX_CYC);

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic              rst_pin;      // device reset pin, high = reset / program
    logic              code_fetch_strobe; // low in programming
    logic              prog_n;       // program strobe, active low
    logic              external_access_pin;
    logic              vpp_high;     // 12 V present on access pin
    logic [4:0]        mode;         // {p2_6, p2_7, p3_3, p3_6, p3_7}
    logic [ADDR_W-1:0] addr;         // {p3_4, p2_5..0, p1_7..0}
    logic [7:0]        data;
  } ocp_pgm_in_t;

  typedef struct packed {
    logic [7:0] data;
    logic       data_oe;
    logic       ready_busy_out;
  } ocp_pgm_out_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } ocp_state_t;

endpackage

// [rtl/ocp_mem.sv]
// byte-wide code array with one write port and a registered read port
// assumes write and read addresses are inside the array depth
`timescale 1ns/100ps
module ocp_mem #(
  parameter int DEPTH  = 20480,
  parameter int ADDR_W = 15
) (
  input  wire logic              clk,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [7:0]        wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [7:0]        rdata_q
);

  logic [7:0] mem [DEPTH];

  // ------------------------------------------------------------
  // storage; no reset so it maps onto an array macro
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data leaves through a register
  always_ff @(posedge clk) begin
    rdata_q <= mem[raddr];
  end

endmodule

// [rtl/ocp_prog.sv]
// program, verify and lock-protection logic of the one-time code memory
// assumes programmer pins are synchronous to pclk and software uses apb
`timescale 1ns/100ps
module ocp_prog #(
  parameter int MEM_DEPTH = 20480
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire ocp_pkg::ocp_pgm_in_t  pgm_i,
  output ocp_pkg::ocp_pgm_out_t      pgm_o,
  input  wire logic               code_table_read_ext,
  output logic                    code_table_read_block,
  output logic                    ext_exec_block,
  output logic                    ea_effective
);
  import ocp_pkg::*;

  localparam int WR_MAX_A   = WR_MAX_CYC;
  localparam int BUSY_MAX_A = BUSY_MAX_CYC;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  ocp_state_t        state_q;
  logic [2:0]        lock_q;          // first, second, third lock bit
  logic              ea_latch_q;
  logic              prog_n_q;
  logic              strobe_rise;
  logic              pgm_active;
  logic              do_wr_code;
  logic [11:0]       wcnt_q;
  logic [11:0]       wtime_q;
  logic              pgm_en_q;
  logic              refused_q;
  logic [15:0]       wdone_q;
  logic [ADDR_W-1:0] last_addr_q;
  logic [7:0]        last_data_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [4:0]        rd_mode_q;
  logic              rd_act_q;
  logic [7:0]        mem_rdata;
  logic [7:0]        rd_byte;
  ocp_pgm_out_t      pgm_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              cpu_block_q;
  logic              ext_block_q;
  logic              ea_eff_q;
  logic              apb_wr;
  logic              apb_setup;
  logic              wr_refused;

  // pick the signature byte for an address
  function automatic logic [7:0] sig_byte(input logic [ADDR_W-1:0] a);
    if (a == SIG_ADDR_MAKER) begin
      sig_byte = SIG_MAKER;
    end else if (a == SIG_ADDR_FAMILY) begin
      sig_byte = SIG_FAMILY;
    end else if (a == SIG_ADDR_PART) begin
      sig_byte = SIG_PART;
    end else begin
      sig_byte = 8'h00;
    end
  endfunction

  // ------------------------------------------------------------
  // operation decode
  // ------------------------------------------------------------
  // programming mode needs reset pin high and fetch strobe low
  assign pgm_active  = pgm_i.rst_pin & ~pgm_i.code_fetch_strobe;
  assign strobe_rise = pgm_i.prog_n & ~prog_n_q;
  // writes act on the strobe's rising edge with 12 V applied
  assign do_wr_code  = pgm_active & pgm_i.vpp_high & strobe_rise & pgm_en_q
                     & (pgm_i.mode == MODE_WR_CODE) & ~lock_q[0]
                     & (state_q == ST_IDLE);
  assign wr_refused  = pgm_active & pgm_i.vpp_high & strobe_rise
                     & (pgm_i.mode == MODE_WR_CODE) & ~do_wr_code;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_n_q <= 1'b1;
    end else begin
      prog_n_q <= pgm_i.prog_n;
    end
  end

  // ------------------------------------------------------------
  // code array
  // ------------------------------------------------------------
  ocp_mem #(
    .DEPTH  (MEM_DEPTH),
    .ADDR_W (ADDR_W)
  ) u_mem (
    .clk     (pclk),
    .we      (do_wr_code),
    .waddr   (pgm_i.addr),
    .wdata   (pgm_i.data),
    .raddr   (pgm_i.addr),
    .rdata_q (mem_rdata)
  );

  // ------------------------------------------------------------
  // self-timed write sequencer
  // ------------------------------------------------------------
  // the array is written at the strobe; the timer only models cell settling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      wcnt_q  <= 12'h000;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (do_wr_code) begin
            state_q <= ST_BUSY;
            wcnt_q  <= wtime_q;
          end
        end
        ST_BUSY: begin
          if (wcnt_q <= 12'h001) begin
            state_q <= ST_IDLE;
          end else begin
            wcnt_q <= wcnt_q - 12'h001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // remember the byte being written for data polling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_addr_q <= '0;
      last_data_q <= 8'h00;
    end else if (do_wr_code) begin
      last_addr_q <= pgm_i.addr;
      last_data_q <= pgm_i.data;
    end
  end

  // ------------------------------------------------------------
  // lock bits and access latch
  // ------------------------------------------------------------
  // lock writes stay allowed after the first lock so higher levels can be set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 3'b000;
    end else if (pgm_active & pgm_i.vpp_high & strobe_rise & pgm_en_q) begin
      if (pgm_i.mode == MODE_WR_LB1) begin
        lock_q[0] <= 1'b1;
      end
      if (pgm_i.mode == MODE_WR_LB2) begin
        lock_q[1] <= 1'b1;
      end
      if (pgm_i.mode == MODE_WR_LB3) begin
        lock_q[2] <= 1'b1;
      end
    end
  end

  // sampled only while the reset pin is high and the first lock is set; otherwise holds its value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ea_latch_q <= 1'b0;
    end else if (pgm_i.rst_pin && lock_q[0]) begin
      ea_latch_q <= pgm_i.external_access_pin;
    end
  end

  // cpu-facing protections; under the first lock the effective level comes from the latch, not the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_block_q <= 1'b0;
      ext_block_q <= 1'b0;
      ea_eff_q    <= 1'b0;
    end else begin
      cpu_block_q <= lock_q[0] & code_table_read_ext;
      ext_block_q <= lock_q[2];
      ea_eff_q    <= lock_q[0] ? ea_latch_q : pgm_i.external_access_pin;
    end
  end

  // ------------------------------------------------------------
  // verify reads
  // ------------------------------------------------------------
  // stage one lines up with the array's registered read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_addr_q <= '0;
      rd_mode_q <= MODE_RD_SIG;
      rd_act_q  <= 1'b0;
    end else begin
      rd_addr_q <= pgm_i.addr;
      rd_mode_q <= pgm_i.mode;
      rd_act_q  <= pgm_active & ~pgm_i.mode[MODE_EN_BIT];
    end
  end

  // choose what goes on the data lines
  always_comb begin
    rd_byte = 8'h00;
    if (rd_mode_q == MODE_RD_SIG) begin
      rd_byte = sig_byte(rd_addr_q);
    end else if (rd_mode_q == MODE_RD_CODE) begin
      if (lock_q[1]) begin
        rd_byte = 8'h00;
      end else if ((state_q == ST_BUSY) && (rd_addr_q == last_addr_q)) begin
        rd_byte = {~last_data_q[7], last_data_q[6:0]};
      end else begin
        rd_byte = mem_rdata;
      end
    end else if (rd_mode_q == MODE_RD_LOCK) begin
      rd_byte = 8'h00;
    end
  end

  // pin outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pgm_q <= '{data: 8'h00, data_oe: 1'b0, ready_busy_out: 1'b1};
    end else begin
      pgm_q.data           <= rd_byte;
      pgm_q.data_oe        <= rd_act_q;
      pgm_q.ready_busy_out <= ~(do_wr_code | (state_q == ST_BUSY) & (wcnt_q > 12'h001));
    end
  end

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready_q & pwrite;

  // one wait-free access phase; data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup & ~((paddr == OFF_CTRL) | (paddr == OFF_WTIME)
                                 | (paddr == OFF_STATUS) | (paddr == OFF_WCOUNT));
      prdata_q  <= 32'h0000_0000;
      if (apb_setup && !pwrite) begin
        unique case (paddr)
          OFF_CTRL:   prdata_q <= {31'h0000_0000, pgm_en_q};
          OFF_WTIME:  prdata_q <= {20'h0_0000, wtime_q};
          OFF_STATUS: prdata_q <= {29'h0000_0000, refused_q, ea_latch_q,
                                   state_q == ST_BUSY};
          OFF_WCOUNT: prdata_q <= {16'h0000, wdone_q};
          default:    prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control registers; write time is clamped to the longest legal write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pgm_en_q <= CTRL_PGM_EN_RST;
      wtime_q  <= WTIME_RST;
    end else if (apb_wr) begin
      if (paddr == OFF_CTRL) begin
        pgm_en_q <= pwdata[CTRL_PGM_EN_BIT];
      end
      if (paddr == OFF_WTIME) begin
        if (pwdata[11:0] > WTIME_MAX) begin
          wtime_q <= WTIME_MAX;
        end else if (pwdata[11:0] == 12'h000) begin
          wtime_q <= 12'h001;
        end else begin
          wtime_q <= pwdata[11:0];
        end
      end
    end
  end

  // refused-write flag: a new refusal wins over a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_q <= 1'b0;
    end else if (wr_refused) begin
      refused_q <= 1'b1;
    end else if (apb_wr && (paddr == OFF_STATUS) && pwdata[STAT_REFUSED_BIT]) begin
      refused_q <= 1'b0;
    end
  end

  // byte writes counted when accepted at the strobe, wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdone_q <= 16'h0000;
    end else if (do_wr_code) begin
      wdone_q <= wdone_q + 16'h0001;
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign pgm_o                 = pgm_q;
  assign code_table_read_block = cpu_block_q;
  assign ext_exec_block        = ext_block_q;
  assign ea_effective          = ea_eff_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  logic [12:0] busy_cyc_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cyc_q <= 13'h0000;
    end else if (!pgm_q.ready_busy_out) begin
      busy_cyc_q <= busy_cyc_q + 13'h0001;
    end else begin
      busy_cyc_q <= 13'h0000;
    end
  end

  property p_lock1_refuse;
    @(posedge pclk) disable iff (!presetn)
      lock_q[0] && strobe_rise |=> (state_q == ST_IDLE) && pgm_o.ready_busy_out;
  endproperty
  a_lock1_refuse: assert property (p_lock1_refuse)
    else $error("write started with first lock set");

  property p_lock2_verify;
    @(posedge pclk) disable iff (!presetn)
      pgm_active && lock_q[1] && (pgm_i.mode == MODE_RD_CODE) |-> ##2 pgm_o.data == 8'h00;
  endproperty
  a_lock2_verify: assert property (p_lock2_verify)
    else $error("code data returned under second lock");

  property p_lock3_exec;
    @(posedge pclk) disable iff (!presetn)
      $rose(lock_q[2]) |=> ext_exec_block;
  endproperty
  a_lock3_exec: assert property (p_lock3_exec)
    else $error("external execution not blocked");

  property p_ea_hold;
    @(posedge pclk) disable iff (!presetn)
      !pgm_i.rst_pin |=> $stable(ea_latch_q);
  endproperty
  a_ea_hold: assert property (p_ea_hold)
    else $error("access latch changed outside reset");

  property p_wr_bound;
    @(posedge pclk) disable iff (!presetn)
      busy_cyc_q <= 13'(WR_MAX_A);
  endproperty
  a_wr_bound: assert property (p_wr_bound)
    else $error("byte write longer than limit");

  property p_poll;
    @(posedge pclk) disable iff (!presetn)
      pgm_active && !lock_q[1] && (pgm_i.mode == MODE_RD_CODE) && (state_q == ST_BUSY)
      && (wcnt_q > 12'h003) && (pgm_i.addr == last_addr_q)
      |-> ##2 pgm_o.data[7] == ~last_data_q[7];
  endproperty
  a_poll: assert property (p_poll)
    else $error("polling bit not inverted while busy");

  property p_busy_soon;
    @(posedge pclk) disable iff (!presetn)
      do_wr_code |-> ##[1:BUSY_MAX_A] !pgm_o.ready_busy_out;
  endproperty
  a_busy_soon: assert property (p_busy_soon)
    else $error("busy not shown in time");

  property p_ready_back;
    @(posedge pclk) disable iff (!presetn)
      $fell(state_q == ST_BUSY) |-> pgm_o.ready_busy_out;
  endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("ready not restored at write end");

  property p_verify_valid;
    @(posedge pclk) disable iff (!presetn)
      presetn && pgm_active && !pgm_i.mode[MODE_EN_BIT] |-> ##2 pgm_o.data_oe; // skip reset edge
  endproperty
  a_verify_valid: assert property (p_verify_valid)
    else $error("verify data not driven");

  property p_sig_maker;
    @(posedge pclk) disable iff (!presetn)
      pgm_active && (pgm_i.mode == MODE_RD_SIG) && (pgm_i.addr == SIG_ADDR_MAKER)
      |-> ##2 pgm_o.data == SIG_MAKER;
  endproperty
  a_sig_maker: assert property (p_sig_maker)
    else $error("wrong maker signature");

  property p_lock_hidden;
    @(posedge pclk) disable iff (!presetn)
      pgm_active && (pgm_i.mode == MODE_RD_LOCK) |-> ##2 pgm_o.data == 8'h00;
  endproperty
  a_lock_hidden: assert property (p_lock_hidden)
    else $error("lock state read out");

endmodule

// [sim/ocp_pgmr.sv]
// device programmer model driving the parallel programming pins
// assumes pins are sampled by the device on rising pclk
`timescale 1ns/100ps
module ocp_pgmr (
  input  wire logic         pclk,
  input  wire ocp_pkg::ocp_pgm_out_t pgm_o,
  output ocp_pkg::ocp_pgm_in_t       pgm_i
);
  import ocp_pkg::*;

  // idle: programming entry held, strobe high, access pin high
  initial begin
    pgm_i = '0;
    pgm_i.rst_pin = 1'b1;
    pgm_i.prog_n = 1'b1;
    pgm_i.external_access_pin = 1'b1;
  end

  // one strobed write; t_busy is cycles from strobe rise to busy, -1 if none
  task automatic pulse(input logic [4:0] m, input logic [14:0] a, input logic [7:0] d,
                       input int w, output int t_busy);
    t_busy = -1;
    @(posedge pclk);
    pgm_i.addr <= a;
    pgm_i.data <= d;
    pgm_i.mode <= m;
    pgm_i.vpp_high <= 1'b1;
    repeat (48) @(posedge pclk);
    pgm_i.prog_n <= 1'b0;
    repeat (w) @(posedge pclk);
    pgm_i.prog_n <= 1'b1;
    for (int i = 0; i < 48; i++) begin
      @(posedge pclk);
      if (t_busy < 0 && pgm_o.ready_busy_out === 1'b0) t_busy = i;
    end
    pgm_i.vpp_high <= 1'b0;
    pgm_i.data <= ~d;                     // released lines never keep the old byte
  endtask

  // verify read: data taken after the longest allowed access time
  task automatic fetch(input logic [4:0] m, input logic [14:0] a, output logic [7:0] q);
    @(posedge pclk);
    pgm_i.addr <= a;
    pgm_i.mode <= m;
    repeat (VERIFY_OSC) @(posedge pclk);
    q = pgm_o.data;
  endtask

  // poll ready before any next write; bounded so a stuck busy cannot hang
  task automatic wait_ready(output int n);
    n = 0;
    while (pgm_o.ready_busy_out !== 1'b1 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // access pin held at the level later latched
  task automatic set_access(input logic v);
    @(posedge pclk);
    pgm_i.external_access_pin <= v;
  endtask

  // reset pin level; low leaves programming mode and freezes the access latch
  task automatic set_reset(input logic v);
    @(posedge pclk);
    pgm_i.rst_pin <= v;
  endtask
endmodule

// [sim/otp_code_program_and_lock_bench.sv]
// self-checking bench: apb master, programmer model, lock sequence
// assumes the package constants and a 40 MHz pclk
`timescale 1ns/100ps
module otp_code_program_and_lock_bench;
  import ocp_pkg::*;
  localparam int WT = 200;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic  [11:0] paddr;
  logic  [31:0] pwdata, prdata;
  ocp_pgm_in_t  pgm_i;
  ocp_pgm_out_t pgm_o;
  logic         ctr_ext, ctr_blk, xblk, eaf;
  int           failures = 0;
  int           n_compared = 0;

  ocp_prog #(.MEM_DEPTH(MEM_DEPTH)) ocp_prog_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pgm_i(pgm_i), .pgm_o(pgm_o),
    .code_table_read_ext(ctr_ext), .code_table_read_block(ctr_blk),
    .ext_exec_block(xblk), .ea_effective(eaf));
  ocp_pgmr ocp_pgmr_i (.pclk(pclk), .pgm_o(pgm_o), .pgm_i(pgm_i));

  // ----------------------------------------------------------
  // clock, watchdog, compare and bus tasks
  // ----------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // lock strobes dominate the run; 40000 cycles leaves ample margin
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end

  task automatic tally_and_finish;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk32({24'h0, got}, {24'h0, exp});
  endtask

  function automatic logic [7:0] sig(int i);
    return i == 0 ? SIG_MAKER : i == 1 ? SIG_FAMILY : SIG_PART;
  endfunction

  // request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic        e, v;
    logic [7:0]  b;
    logic [14:0] ad[4];
    logic [7:0]  dt[4];
    int          tb, n;
    void'($urandom(32'h96821793));
    {presetn, psel, penable, pwrite, paddr, pwdata, ctr_ext} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    ctr_ext <= 1'b1;
    apb(0, OFF_CTRL, 0, q, e);
    chk32(q, 32'h1);
    apb(0, OFF_WTIME, 0, q, e);
    chk32(q, 32'd2000);
    apb(0, OFF_STATUS, 0, q, e);
    chk32(q, 32'h0);
    apb(0, 12'h010, 0, q, e);
    chk32({q[30:0], e}, 32'h1);
    // write time clamps at both ends
    apb(1, OFF_WTIME, 32'hfff, q, e);
    apb(0, OFF_WTIME, 0, q, e);
    chk32(q, 32'(WR_MAX_CYC));
    apb(1, OFF_WTIME, 0, q, e);
    apb(0, OFF_WTIME, 0, q, e);
    chk32(q, 32'h1);
    apb(1, OFF_WTIME, WT, q, e);
    chk32({31'h0, ctr_blk}, 32'h0);
    // random bytes, top address as the boundary case
    for (int i = 0; i < 4; i++) begin
      ad[i] = i == 0 ? 15'(MEM_DEPTH - 1) : 15'(i * 5000 + $urandom % 5000);
      dt[i] = 8'($urandom);
      ocp_pgmr_i.pulse(MODE_WR_CODE, ad[i], dt[i], 8, tb);
      chk32(32'(tb inside {[1:BUSY_MAX_CYC]}), 1);
      apb(0, OFF_STATUS, 0, q, e);
      chk32(q & 32'h1, 32'h1);
      ocp_pgmr_i.fetch(MODE_RD_CODE, ad[i], b);
      chk8(b, dt[i] ^ 8'h80);
      ocp_pgmr_i.wait_ready(n);
      chk32(32'(n > 0 && n <= WT && WT <= WR_MAX_CYC), 1);
      ocp_pgmr_i.fetch(MODE_RD_CODE, ad[i], b);
      chk8(b, dt[i]);
    end
    apb(0, OFF_WCOUNT, 0, q, e);
    chk32(q, 32'd4);
    for (int i = 0; i < 3; i++) begin
      ocp_pgmr_i.fetch(MODE_RD_SIG, 15'(i * 256), b);
      chk8(b, sig(i));
    end
    ocp_pgmr_i.fetch(MODE_RD_LOCK, 15'h0, b);
    chk8(b, 8'h00);
    // software disable refuses a strobe and flags it
    apb(1, OFF_CTRL, 0, q, e);
    ocp_pgmr_i.pulse(MODE_WR_CODE, ad[1], ~dt[1], 8, tb);
    chk32(32'(tb), '1);
    apb(0, OFF_STATUS, 0, q, e);
    chk32(q & 32'h4, 32'h4);
    apb(1, OFF_STATUS, 32'h4, q, e);
    apb(1, OFF_CTRL, 1, q, e);
    // first lock: latch, table-read block, no more code writes
    ocp_pgmr_i.pulse(MODE_WR_LB1, 15'h0, 8'h00, 4000, tb);
    ocp_pgmr_i.wait_ready(n);
    v = 1'($urandom);
    ocp_pgmr_i.set_access(v);
    repeat (2) @(posedge pclk);
    apb(0, OFF_STATUS, 0, q, e);
    chk32({31'h0, q[1]}, {31'h0, v});
    chk32({31'h0, ctr_blk}, 32'h1);
    // reset pin low: latch and effective level hold while the pin moves
    ocp_pgmr_i.set_reset(1'b0);
    ocp_pgmr_i.set_access(~v);
    ctr_ext <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(0, OFF_STATUS, 0, q, e);
    chk32({31'h0, q[1]}, {31'h0, v});
    chk32({31'h0, eaf}, {31'h0, v});
    chk32({31'h0, ctr_blk}, 32'h0);
    ocp_pgmr_i.set_access(v);
    ocp_pgmr_i.set_reset(1'b1);
    ctr_ext <= 1'b1;
    ocp_pgmr_i.pulse(MODE_WR_CODE, ad[2], ~dt[2], 8, tb);
    chk32(32'(tb), '1);
    ocp_pgmr_i.fetch(MODE_RD_CODE, ad[2], b);
    chk8(b, dt[2]);
    ocp_pgmr_i.fetch(MODE_RD_LOCK, 15'h0, b);
    chk8(b, 8'h00);
    // second lock hides verify data, third stops external execution
    ocp_pgmr_i.pulse(MODE_WR_LB2, 15'h0, 8'h00, 4000, tb);
    ocp_pgmr_i.wait_ready(n);
    ocp_pgmr_i.fetch(MODE_RD_CODE, ad[2], b);
    chk8(b, 8'h00);
    chk32({31'h0, xblk}, 32'h0);
    ocp_pgmr_i.pulse(MODE_WR_LB3, 15'h0, 8'h00, 4000, tb);
    ocp_pgmr_i.wait_ready(n);
    chk32({31'h0, xblk}, 32'h1);
    tally_and_finish();
  end
endmodule
